// File: afcb_pkg.sv
package afcb_pkg;

  // Register geometry
  localparam int unsigned REG_WIDTH   = 8;
  localparam int unsigned ADDR_WIDTH  = 8;
  localparam int unsigned COEFF_WIDTH = 16;
  localparam int unsigned NUM_PAIRS   = 6;

  // Register offsets
  localparam logic [7:0] LEFT_FX_DEN4_HIGH_OFFSET     = 8'h11;
  localparam logic [7:0] LEFT_FX_DEN4_LOW_OFFSET      = 8'h12;
  localparam logic [7:0] LEFT_FX_DEN5_HIGH_OFFSET     = 8'h13;
  localparam logic [7:0] LEFT_FX_DEN5_LOW_OFFSET      = 8'h14;
  localparam logic [7:0] LEFT_DEEMPH_NUM0_HIGH_OFFSET = 8'h15;
  localparam logic [7:0] LEFT_DEEMPH_NUM0_LOW_OFFSET  = 8'h16;
  localparam logic [7:0] LEFT_DEEMPH_NUM1_HIGH_OFFSET = 8'h17;
  localparam logic [7:0] LEFT_DEEMPH_NUM1_LOW_OFFSET  = 8'h18;
  localparam logic [7:0] LEFT_DEEMPH_DEN1_HIGH_OFFSET = 8'h19;
  localparam logic [7:0] LEFT_DEEMPH_DEN1_LOW_OFFSET  = 8'h1a;
  localparam logic [7:0] RIGHT_FX_NUM0_HIGH_OFFSET    = 8'h1b;
  localparam logic [7:0] RIGHT_FX_NUM0_LOW_OFFSET     = 8'h1c;

  // Reset values
  localparam logic [7:0] LEFT_FX_DEN4_HIGH_RST     = 8'h7d;
  localparam logic [7:0] LEFT_FX_DEN4_LOW_RST      = 8'h83;
  localparam logic [7:0] LEFT_FX_DEN5_HIGH_RST     = 8'h84;
  localparam logic [7:0] LEFT_FX_DEN5_LOW_RST      = 8'hee;
  localparam logic [7:0] LEFT_DEEMPH_NUM0_HIGH_RST = 8'h39;
  localparam logic [7:0] LEFT_DEEMPH_NUM0_LOW_RST  = 8'h55;
  localparam logic [7:0] LEFT_DEEMPH_NUM1_HIGH_RST = 8'hf3;
  localparam logic [7:0] LEFT_DEEMPH_NUM1_LOW_RST  = 8'h2d;
  localparam logic [7:0] LEFT_DEEMPH_DEN1_HIGH_RST = 8'h53;
  localparam logic [7:0] LEFT_DEEMPH_DEN1_LOW_RST  = 8'h7e;
  localparam logic [7:0] RIGHT_FX_NUM0_HIGH_RST    = 8'h6b;
  localparam logic [7:0] RIGHT_FX_NUM0_LOW_RST     = 8'he3;

  // Pair tables, pair 0 in the lowest byte
  localparam logic [NUM_PAIRS*8-1:0] HI_ADDR_TABLE = {
    RIGHT_FX_NUM0_HIGH_OFFSET, LEFT_DEEMPH_DEN1_HIGH_OFFSET, LEFT_DEEMPH_NUM1_HIGH_OFFSET,
    LEFT_DEEMPH_NUM0_HIGH_OFFSET, LEFT_FX_DEN5_HIGH_OFFSET, LEFT_FX_DEN4_HIGH_OFFSET};
  localparam logic [NUM_PAIRS*8-1:0] LO_ADDR_TABLE = {
    RIGHT_FX_NUM0_LOW_OFFSET, LEFT_DEEMPH_DEN1_LOW_OFFSET, LEFT_DEEMPH_NUM1_LOW_OFFSET,
    LEFT_DEEMPH_NUM0_LOW_OFFSET, LEFT_FX_DEN5_LOW_OFFSET, LEFT_FX_DEN4_LOW_OFFSET};
  localparam logic [NUM_PAIRS*8-1:0] HI_RST_TABLE = {
    RIGHT_FX_NUM0_HIGH_RST, LEFT_DEEMPH_DEN1_HIGH_RST, LEFT_DEEMPH_NUM1_HIGH_RST,
    LEFT_DEEMPH_NUM0_HIGH_RST, LEFT_FX_DEN5_HIGH_RST, LEFT_FX_DEN4_HIGH_RST};
  localparam logic [NUM_PAIRS*8-1:0] LO_RST_TABLE = {
    RIGHT_FX_NUM0_LOW_RST, LEFT_DEEMPH_DEN1_LOW_RST, LEFT_DEEMPH_NUM1_LOW_RST,
    LEFT_DEEMPH_NUM0_LOW_RST, LEFT_FX_DEN5_LOW_RST, LEFT_FX_DEN4_LOW_RST};

  // Unmapped reads
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

endpackage

// File: afcb_coeff_pair.sv
`timescale 1ns/1ps
module afcb_coeff_pair #(
  parameter logic [7:0] HI_RST = 8'h00,
  parameter logic [7:0] LO_RST = 8'h00
) (
  // Clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_rstn,
  // Byte writes
  input  wire logic               i_wr_hi,
  input  wire logic               i_wr_lo,
  input  wire logic [7:0]         i_wdata,
  // Register and coefficient state
  output logic       [7:0]        o_hi,
  output logic       [7:0]        o_lo,
  output logic signed [15:0]      o_coeff,
  output logic                    o_pending
);

  logic [7:0]         hi_r;
  logic [7:0]         hi_nxt;
  logic [7:0]         lo_r;
  logic [7:0]         lo_nxt;
  logic signed [15:0] coeff_r;
  logic signed [15:0] coeff_nxt;
  logic               pending_r;
  logic               pending_nxt;

  always_comb begin
    hi_nxt      = hi_r;
    lo_nxt      = lo_r;
    coeff_nxt   = coeff_r;
    pending_nxt = pending_r;
    if (i_wr_hi) begin
      hi_nxt      = i_wdata;
      pending_nxt = 1'b1;
    end
    // Low byte commits the pair; a lone high write waits here
    if (i_wr_lo) begin
      lo_nxt      = i_wdata;
      coeff_nxt   = signed'({hi_nxt, i_wdata});
      pending_nxt = i_wr_hi;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hi_r      <= HI_RST;
      lo_r      <= LO_RST;
      coeff_r   <= signed'({HI_RST, LO_RST});
      pending_r <= 1'b0;
    end else begin
      hi_r      <= hi_nxt;
      lo_r      <= lo_nxt;
      coeff_r   <= coeff_nxt;
      pending_r <= pending_nxt;
    end
  end

  assign o_hi      = hi_r;
  assign o_lo      = lo_r;
  assign o_coeff   = coeff_r;
  assign o_pending = pending_r;

endmodule

// File: afcb_coeff_bank.sv
`timescale 1ns/1ps
//
// Behaviour
// - High and low byte of a pair form one signed 16-bit coefficient, high on top.
// - Coefficient spans -32768 to +32767 with no scaling or saturation.
// - Every register is eight bits wide, fully readable and writable.
// - Left effects denominator tap four low byte resets to 0x83.
// - Left effects denominator tap five resets to high 0x84, low 0xee.
// - Left de-emphasis numerator tap zero resets to high 0x39, low 0x55.
// - Left de-emphasis numerator tap one resets to high 0xf3, low 0x2d.
// - Left de-emphasis denominator tap one resets to high 0x53, low 0x7e.
// - Right effects numerator tap zero high byte resets to 0x6b.
// - Left effects denominator tap four high byte resets to 0x7d.
// - Right effects numerator tap zero low byte resets to 0xe3.
module afcb_coeff_bank (
  // Clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rstn,
  // Register port from the control bus logic
  input  wire logic [7:0]               i_reg_addr,
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  input  wire logic [7:0]               i_reg_wdata,
  output logic       [7:0]              o_reg_rdata,
  output logic                          o_reg_rvalid,
  output logic                          o_reg_err,
  // Coefficients to the filter datapath
  output logic signed [15:0]            o_left_fx_den_tap_four,
  output logic signed [15:0]            o_left_fx_den_tap_five,
  output logic signed [15:0]            o_left_deemph_num_tap_zero,
  output logic signed [15:0]            o_left_deemph_num_tap_one,
  output logic signed [15:0]            o_left_deemph_den_tap_one,
  output logic signed [15:0]            o_right_fx_num_tap_zero,
  // High byte written, low byte still awaited
  output logic [afcb_pkg::NUM_PAIRS-1:0] o_coeff_pending
);

  localparam int unsigned NP = afcb_pkg::NUM_PAIRS;

  // Returns {hit, is_high, pair index}
  function automatic logic [4:0] afcb_decode(input logic [7:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int k = 0; k < NP; k++) begin
      if (addr == afcb_pkg::HI_ADDR_TABLE[8*k +: 8]) begin
        res = {1'b1, 1'b1, 3'(k)};
      end
      if (addr == afcb_pkg::LO_ADDR_TABLE[8*k +: 8]) begin
        res = {1'b1, 1'b0, 3'(k)};
      end
    end
    return res;
  endfunction

  logic [4:0]         dec;
  logic               dec_hit;
  logic               dec_hi;
  logic [2:0]         dec_idx;
  logic [NP-1:0]      wr_hi;
  logic [NP-1:0]      wr_lo;
  logic [7:0]         hi_byte  [NP];
  logic [7:0]         lo_byte  [NP];
  logic signed [15:0] coeff    [NP];
  logic [NP-1:0]      pending;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic               rvalid_r;
  logic               rvalid_nxt;
  logic               err_r;
  logic               err_nxt;

  assign dec     = afcb_decode(i_reg_addr);
  assign dec_hit = dec[4];
  assign dec_hi  = dec[3];
  assign dec_idx = dec[2:0];

  // Coefficient pairs; reset values come from the pair tables
  for (genvar g = 0; g < NP; g++) begin : g_pair
    assign wr_hi[g] = i_reg_wr && dec_hit && dec_hi && (dec_idx == 3'(g));
    assign wr_lo[g] = i_reg_wr && dec_hit && !dec_hi && (dec_idx == 3'(g));
    afcb_coeff_pair #(
      .HI_RST (afcb_pkg::HI_RST_TABLE[8*g +: 8]),
      .LO_RST (afcb_pkg::LO_RST_TABLE[8*g +: 8])
    ) u_pair (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_wr_hi    (wr_hi[g]),
      .i_wr_lo    (wr_lo[g]),
      .i_wdata    (i_reg_wdata),
      .o_hi       (hi_byte[g]),
      .o_lo       (lo_byte[g]),
      .o_coeff    (coeff[g]),
      .o_pending  (pending[g])
    );
  end

  // Read returns the stored byte before any same-cycle write
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    err_nxt    = 1'b0;
    if (i_reg_rd) begin
      rvalid_nxt = 1'b1;
      if (dec_hit) begin
        rdata_nxt = dec_hi ? hi_byte[dec_idx] : lo_byte[dec_idx];
      end else begin
        rdata_nxt = afcb_pkg::UNMAPPED_READ_VALUE;
        err_nxt   = 1'b1;
      end
    end else if (i_reg_wr && !dec_hit) begin
      // Unmapped writes change nothing but are flagged
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      err_r    <= err_nxt;
    end
  end

  assign o_reg_rdata  = rdata_r;
  assign o_reg_rvalid = rvalid_r;
  assign o_reg_err    = err_r;

  // Straight from the committed pair registers, no scaling
  assign o_left_fx_den_tap_four     = coeff[0];
  assign o_left_fx_den_tap_five     = coeff[1];
  assign o_left_deemph_num_tap_zero = coeff[2];
  assign o_left_deemph_num_tap_one  = coeff[3];
  assign o_left_deemph_den_tap_one  = coeff[4];
  assign o_right_fx_num_tap_zero    = coeff[5];
  assign o_coeff_pending            = pending;

endmodule

// File: afcb_coeff_bank_chk.sv
`timescale 1ns/1ps
module afcb_coeff_bank_chk (
  // Clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_rstn,
  // Register port
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  input  wire logic [7:0]         i_reg_wdata,
  input  wire logic [7:0]         o_reg_rdata,
  input  wire logic               o_reg_rvalid,
  input  wire logic               o_reg_err,
  // Watched coefficient pair
  input  wire logic signed [15:0] o_left_fx_den_tap_five,
  input  wire logic [5:0]         o_coeff_pending
);
  logic bad;
  logic wr_lo;
  logic [7:0] hi_seen;
  // Tracks the tap five high byte so the commit check sees both halves
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hi_seen <= 8'h84;
    end else if (i_reg_wr && (i_reg_addr == 8'h13)) begin
      hi_seen <= i_reg_wdata;
    end
  end
  assign bad = (i_reg_rd || i_reg_wr) && !((i_reg_addr >= 8'h11) && (i_reg_addr <= 8'h1c));
  assign wr_lo = i_reg_wr && (i_reg_addr == 8'h14);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  a_valid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("read valid without read");
  a_unmapped_err: assert property (bad |=> o_reg_err)
    else $error("unmapped access not flagged");
  a_err_cause: assert property (o_reg_err |-> $past(bad))
    else $error("error flag without cause");
  a_unmapped_zero: assert property (i_reg_rd && bad |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");
  a_pend_set: assert property (i_reg_wr && i_reg_addr == 8'h13 |=> o_coeff_pending[1])
    else $error("pending not set by high write");
  a_low_commit: assert property (wr_lo |=> !o_coeff_pending[1] &&
    o_left_fx_den_tap_five[7:0] == $past(i_reg_wdata)) else $error("low write not committed");
  a_high_commit: assert property (wr_lo |=>
    o_left_fx_den_tap_five[15:8] == $past(hi_seen)) else $error("low write lost high byte");
  a_coeff_hold: assert property (!wr_lo |=> $stable(o_left_fx_den_tap_five))
    else $error("coefficient moved without low write");
  c_pair: cover property (i_reg_wr && i_reg_addr == 8'h13 ##2 wr_lo);
  c_err: cover property (o_reg_err);
  c_read: cover property (o_reg_rvalid);
endmodule

bind afcb_coeff_bank afcb_coeff_bank_chk u_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_reg_err(o_reg_err),
  .o_left_fx_den_tap_five(o_left_fx_den_tap_five), .o_coeff_pending(o_coeff_pending));

// File: afcb_host_model.sv
`timescale 1ns/1ps
module afcb_host_model (
  input  wire logic       i_core_clk,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // Released address and data lines show the inverse and the strobes drop low, so stale values never pass
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
  endtask
endmodule

// File: test_audio_filter_coeff_bank.sv
`timescale 1ns/1ps
module test_audio_filter_coeff_bank;
  localparam logic [95:0] RV = 96'h7d83_84ee_3955_f32d_537e_6be3;
  logic              i_core_clk = 1'b0;
  logic              i_rstn = 1'b0;
  logic [7:0]        ra, rw, q, m [12];
  logic              wr, rd, rv, er;
  logic signed [15:0] c [6];
  logic [15:0]       cx [6];
  logic [5:0]        pd, px;
  int                n_errors = 0;
  int                checks = 0;
  always #5 i_core_clk = ~i_core_clk;
  afcb_host_model host (.i_core_clk(i_core_clk), .o_addr(ra), .o_wr(wr), .o_rd(rd), .o_wdata(rw));
  afcb_coeff_bank dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_reg_addr(ra),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(rw), .o_reg_rdata(q), .o_reg_rvalid(rv),
    .o_reg_err(er), .o_left_fx_den_tap_four(c[0]), .o_left_fx_den_tap_five(c[1]),
    .o_left_deemph_num_tap_zero(c[2]), .o_left_deemph_num_tap_one(c[3]),
    .o_left_deemph_den_tap_one(c[4]), .o_right_fx_num_tap_zero(c[5]), .o_coeff_pending(pd));
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Expected values from the reset table and the pairing rule
  function automatic logic [7:0] rst_byte(input int i);
    return RV[95-8*i -: 8];
  endfunction
  function automatic logic [15:0] pair_value(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction
  task end_sim();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task do_reset();
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 12; i++) m[i] = rst_byte(i);
    for (int k = 0; k < 6; k++) cx[k] = pair_value(m[2*k], m[2*k+1]);
    px = 6'h00;
  endtask
  task rdchk(input int i, input logic [7:0] e);
    host.xfer(8'h11 + 8'(i), 8'h00, 1'b0);
    chk("rdata", {8'h00, e}, {8'h00, q});
    chk("rvalid", 16'h0001, {15'h0, rv});
  endtask
  // Even index is a high byte; only the low byte commits the pair
  task wrm(input int i, input logic [7:0] d);
    host.xfer(8'h11 + 8'(i), d, 1'b1);
    m[i] = d;
    if (i % 2 == 0) px[i/2] = 1'b1;
    else begin
      cx[i/2] = pair_value(m[i-1], d);
      px[i/2] = 1'b0;
    end
  endtask
  task cchk();
    for (int k = 0; k < 6; k++) chk("coeff", cx[k], c[k]);
    chk("pending", {10'h0, px}, {10'h0, pd});
  endtask
  task sweep();
    for (int i = 0; i < 12; i++) rdchk(i, m[i]);
    cchk();
  endtask
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial begin
    logic [7:0] ua [3];
    ua = '{8'h10, 8'h1d, 8'hff};
    void'($urandom(32'h5c13));
    do_reset();
    sweep();
    repeat (60) begin
      wrm($urandom_range(11), 8'($urandom));
      cchk();
    end
    wrm(2, 8'h80);
    wrm(3, 8'h00);
    wrm(4, 8'h7f);
    wrm(5, 8'hff);
    chk("min", 16'h8000, c[1]);
    chk("max", 16'h7fff, c[2]);
    for (int j = 0; j < 3; j++) begin
      host.xfer(ua[j], 8'h5a, 1'b1);
      chk("err", 16'h0001, {15'h0, er});
      host.xfer(ua[j], 8'h00, 1'b0);
      chk("unmapped", 16'h0001, {7'h0, q, er});
    end
    sweep();
    wrm(0, 8'h12);
    do_reset();
    sweep();
    end_sim();
  end
endmodule
